// ===== rsp_slave_port.sv
// Two-wire slave port giving a host byte access to the register file.
// Assumes an external register file answers regRdData for regPtr in the
// same cycle and keeps its contents on its own, independent of this
// port's interface supply.
`timescale 1ns/100ps

module rsp_slave_port
  import rsp_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // Serial bus pins
  input  wire logic       sclPin,
  input  wire logic       sdaPin,
  output logic            sclOut,
  output logic            sclOe,
  output logic            sdaOut,
  output logic            sdaOe,
  // Options and supply monitors
  input  wire logic       addrSel,
  input  wire logic       testUnlock,
  input  wire logic       interfaceSupplyUndervoltageLevel,
  input  wire logic       systemSupplyUndervoltageLevel,
  // Register file side
  output logic [7:0]      regPtr,
  output logic [7:0]      regWrData,
  output logic            regWrEn,
  output logic            regRdEn,
  input  wire logic [7:0] regRdData,
  // Status
  output logic            hsFilter
);

  // ==========================================================
  // Reset release and option synchronisers
  // ==========================================================
  logic [1:0] rstSync_reg;
  logic       rstN;
  logic [3:0] optMeta_reg;
  logic [3:0] optSync_reg;
  logic [1:0] strapCnt_reg;
  logic       mainSel_reg;
  logic       supplyOff;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      rstSync_reg <= 2'h0;
    else
      rstSync_reg <= {rstSync_reg[0], 1'b1};
  end

  assign rstN = rstSync_reg[1];

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      optMeta_reg <= 4'h0;
      optSync_reg <= 4'h0;
    end
    else
    begin
      optMeta_reg <= {systemSupplyUndervoltageLevel,
                      interfaceSupplyUndervoltageLevel,
                      testUnlock, addrSel};
      optSync_reg <= optMeta_reg;
    end
  end

  // The address option is a strap: followed until the synchroniser has
  // filled with the pin level, then frozen until the next reset
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      strapCnt_reg <= 2'h0;
      mainSel_reg  <= 1'b0;
    end
    else if (strapCnt_reg != STRAP_WAIT)
    begin
      strapCnt_reg <= strapCnt_reg + 2'h1;
      mainSel_reg  <= optSync_reg[0];
    end
  end

  assign supplyOff = optSync_reg[2] & optSync_reg[3];

  // ==========================================================
  // Line conditioning and address decode
  // ==========================================================
  rsp_line_if lineEv ();

  logic       hs_reg;
  logic [7:0] rxByte_reg;
  logic       addrHit;
  logic       hsCode;

  rsp_line_sync uLineSync (
    .clk      (clk),
    .rstN     (rstN),
    .sclPin   (sclPin),
    .sdaPin   (sdaPin),
    .hsFilter (hs_reg),
    .lineEv   (lineEv.src)
  );

  rsp_addr_match uAddrMatch (
    .addrByte (rxByte_reg),
    .mainSel  (mainSel_reg),
    .testOpen (optSync_reg[1]),
    .addrHit  (addrHit),
    .hsCode   (hsCode)
  );

  // ==========================================================
  // Transfer sequencer
  // ==========================================================
  rsp_state_e state_reg;
  logic [3:0] bitCnt_reg;
  logic       rw_reg;
  logic       masterAck_reg;
  logic [7:0] txByte_reg;
  logic       sdaDrive_reg;
  logic [7:0] ptr_reg;
  logic       byteDone;
  logic       rise;
  logic       fall;
  logic       loadTx;

  assign rise     = lineEv.sclRise;
  assign fall     = lineEv.sclFall;
  assign byteDone = (bitCnt_reg == BYTE_BITS);

  // A start or stop wins over any clock event in the same cycle
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      state_reg     <= ST_IDLE;
      bitCnt_reg    <= 4'h0;
      rxByte_reg    <= 8'h00;
      rw_reg        <= 1'b0;
      masterAck_reg <= 1'b0;
    end
    else if (lineEv.stopSeen)
    begin
      state_reg  <= ST_IDLE;
      bitCnt_reg <= 4'h0;
    end
    else if (lineEv.startSeen)
    begin
      state_reg  <= ST_ADDR;
      bitCnt_reg <= 4'h0;
    end
    else
    begin
      case (state_reg)
        ST_ADDR, ST_PTR, ST_WDATA:
        begin
          if (rise && !byteDone)
          begin
            rxByte_reg <= {rxByte_reg[6:0], lineEv.sdaBit};
            bitCnt_reg <= bitCnt_reg + 4'h1;
          end
          else if (fall && byteDone)
          begin
            bitCnt_reg <= 4'h0;
            if (state_reg == ST_ADDR)
            begin
              rw_reg    <= rxByte_reg[0];
              state_reg <= addrHit ? ST_ADDR_ACK : ST_IDLE;
            end
            else if (state_reg == ST_PTR)
              state_reg <= ST_PTR_ACK;
            else
              state_reg <= ST_WDATA_ACK;
          end
        end
        ST_ADDR_ACK:
        begin
          if (fall)
            state_reg <= rw_reg ? ST_RDATA : ST_PTR;
        end
        ST_PTR_ACK, ST_WDATA_ACK:
        begin
          if (fall)
            state_reg <= ST_WDATA;
        end
        ST_RDATA:
        begin
          if (rise && !byteDone)
            bitCnt_reg <= bitCnt_reg + 4'h1;
          else if (fall && byteDone)
          begin
            bitCnt_reg <= 4'h0;
            state_reg  <= ST_RDATA_ACK;
          end
        end
        ST_RDATA_ACK:
        begin
          if (rise)
            masterAck_reg <= ~lineEv.sdaBit;
          else if (fall)
            state_reg <= masterAck_reg ? ST_RDATA : ST_IDLE;
        end
        default:
        begin
          bitCnt_reg <= 4'h0;  // Idle ignores the clock line
        end
      endcase
    end
  end

  // ==========================================================
  // Transmit byte: fetched at the fall ending an acknowledge
  // ==========================================================
  assign loadTx = fall && !lineEv.stopSeen && !lineEv.startSeen
                  && (((state_reg == ST_ADDR_ACK) && rw_reg)
                      || ((state_reg == ST_RDATA_ACK) && masterAck_reg));
  assign regRdEn = loadTx;

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
      txByte_reg <= 8'h00;
    else if (loadTx)
      txByte_reg <= regRdData;
    else if (fall && (state_reg == ST_RDATA) && !byteDone)
      txByte_reg <= {txByte_reg[6:0], 1'b0};
  end

  // ==========================================================
  // Data line drive: changed on a clock fall, or cleared at a start or stop
  // ==========================================================
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
      sdaDrive_reg <= 1'b0;
    else if (lineEv.stopSeen || lineEv.startSeen)
      sdaDrive_reg <= 1'b0;
    else if (fall)
    begin
      case (state_reg)
        ST_ADDR:
          sdaDrive_reg <= byteDone & addrHit;
        ST_PTR, ST_WDATA:
          sdaDrive_reg <= byteDone;
        ST_ADDR_ACK:
          sdaDrive_reg <= rw_reg & ~regRdData[7];
        ST_RDATA:
          sdaDrive_reg <= ~byteDone & ~txByte_reg[6];
        ST_RDATA_ACK:
          sdaDrive_reg <= masterAck_reg & ~regRdData[7];
        default:
          sdaDrive_reg <= 1'b0;
      endcase
    end
  end

  // Open drain: the data line is only ever pulled low
  assign sdaOut = 1'b0;
  assign sdaOe  = sdaDrive_reg & ~supplyOff;
  // Timing comes only from the master's clock, which is never held
  assign sclOut = 1'b0;
  assign sclOe  = 1'b0;

  // ==========================================================
  // Register pointer: not touched by stop, reset only by rst_b
  // ==========================================================
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
      ptr_reg <= PTR_RESET;
    else if (fall && (state_reg == ST_PTR) && byteDone
             && !lineEv.startSeen && !lineEv.stopSeen)
      ptr_reg <= rxByte_reg;
    else if (fall && (state_reg == ST_WDATA_ACK))
      ptr_reg <= ptr_reg + 8'h01;
    else if (rise && (state_reg == ST_RDATA_ACK))
      ptr_reg <= ptr_reg + 8'h01;
  end

  assign regPtr = ptr_reg;

  // ==========================================================
  // Write strobe: data lands at the acknowledge clock rise
  // ==========================================================
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      regWrEn   <= 1'b0;
      regWrData <= 8'h00;
    end
    else
    begin
      regWrEn <= rise && (state_reg == ST_WDATA_ACK)
                 && !lineEv.stopSeen;
      if (rise && (state_reg == ST_WDATA_ACK))
        regWrData <= rxByte_reg;
    end
  end

  // ==========================================================
  // Input filter setting
  // ==========================================================
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
      hs_reg <= 1'b0;
    else if (lineEv.stopSeen)
      hs_reg <= 1'b0;
    else if (fall && (state_reg == ST_ADDR) && byteDone && hsCode)
      hs_reg <= 1'b1;
  end

  assign hsFilter = hs_reg;

endmodule : rsp_slave_port

// ===== rsp_pkg.sv
// Constants and types shared by the register slave port files.
// Assumes a single 50 MHz system clock drives every module.
package rsp_pkg;

  // ==========================================================
  // Clocking and input filter timing
  // ==========================================================
  localparam int CLK_MHZ       = 50;
  localparam int FILT_STD_NS   = 50;
  localparam int FILT_HS_NS    = 10;
  localparam int FILT_STD_CYC  = (FILT_STD_NS * CLK_MHZ + 999) / 1000;
  localparam int FILT_HS_RAW   = (FILT_HS_NS * CLK_MHZ + 999) / 1000;
  localparam int FILT_HS_CYC   = (FILT_HS_RAW < 1) ? 1 : FILT_HS_RAW;

  // ==========================================================
  // Framing and addressing
  // ==========================================================
  localparam logic [3:0] BYTE_BITS     = 4'h8;
  localparam logic [6:0] ADDR_MAIN_SET = 7'h48;
  localparam logic [6:0] ADDR_MAIN_CLR = 7'h40;
  localparam logic [6:0] ADDR_TEST     = 7'h49;
  localparam logic [4:0] HS_CODE_TOP   = 5'h01;
  localparam logic [7:0] PTR_RESET     = 8'h00;
  localparam logic [1:0] STRAP_WAIT    = 2'h3;

  // ==========================================================
  // Transfer sequencer states
  // ==========================================================
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_PTR,
    ST_PTR_ACK,
    ST_WDATA,
    ST_WDATA_ACK,
    ST_RDATA,
    ST_RDATA_ACK
  } rsp_state_e;

endpackage : rsp_pkg

// ===== rsp_line_if.sv
// Bus line events passed from the line conditioner to the sequencer.
// Assumes both ends run on the same system clock.
`timescale 1ns/100ps
interface rsp_line_if;
  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;
  logic sdaBit;

  modport src (output sclRise, sclFall, startSeen, stopSeen, sdaBit);
  modport dst (input  sclRise, sclFall, startSeen, stopSeen, sdaBit);
endinterface : rsp_line_if

// ===== rsp_line_sync.sv
// Synchronises, filters and edge-detects the serial clock and data pins.
// Assumes pins are asynchronous to clk; rstN is already synchronised.
`timescale 1ns/100ps
module rsp_line_sync
  import rsp_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rstN,
  // Pins and filter choice
  input  wire logic sclPin,
  input  wire logic sdaPin,
  input  wire logic hsFilter,
  // Events out
  rsp_line_if.src   lineEv
);

  logic [1:0] meta_reg;
  logic [1:0] sync_reg;
  logic [1:0] filt_reg;
  logic [1:0] prev_reg;
  logic [2:0] limit;

  // Fast mode plus spikes need a longer hold than high-speed ones
  assign limit = hsFilter ? 3'(FILT_HS_CYC) : 3'(FILT_STD_CYC);

  // ==========================================================
  // Two-stage synchroniser and stability filter per line
  // ==========================================================
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : gLine
      logic [2:0] cnt_reg;
      always_ff @(posedge clk or negedge rstN)
      begin
        if (!rstN)
        begin
          meta_reg[g] <= 1'b1;
          sync_reg[g] <= 1'b1;
          filt_reg[g] <= 1'b1;
          prev_reg[g] <= 1'b1;
          cnt_reg     <= 3'h0;
        end
        else
        begin
          meta_reg[g] <= g ? sdaPin : sclPin;
          sync_reg[g] <= meta_reg[g];
          prev_reg[g] <= filt_reg[g];
          if (sync_reg[g] == filt_reg[g])
            cnt_reg <= 3'h0;
          else if (cnt_reg + 3'h1 >= limit)
          begin
            filt_reg[g] <= sync_reg[g];
            cnt_reg     <= 3'h0;
          end
          else
            cnt_reg <= cnt_reg + 3'h1;
        end
      end
    end
  endgenerate

  // Index 0 is the clock line, index 1 the data line
  assign lineEv.sclRise   = filt_reg[0] & ~prev_reg[0];
  assign lineEv.sclFall   = ~filt_reg[0] & prev_reg[0];
  assign lineEv.startSeen = filt_reg[0] & prev_reg[0]
                            & prev_reg[1] & ~filt_reg[1];
  assign lineEv.stopSeen  = filt_reg[0] & prev_reg[0]
                            & ~prev_reg[1] & filt_reg[1];
  assign lineEv.sdaBit    = filt_reg[1];

endmodule : rsp_line_sync

// ===== rsp_addr_match.sv
// Decodes the first byte after a start: own address or high-speed code.
// Assumes the byte and the option levels are stable when sampled.
`timescale 1ns/100ps
module rsp_addr_match
  import rsp_pkg::*;
(
  // Received byte and options
  input  wire logic [7:0] addrByte,
  input  wire logic       mainSel,
  input  wire logic       testOpen,
  // Decode results
  output logic            addrHit,
  output logic            hsCode
);

  function automatic logic isAddr(input logic [7:0] b,
                                  input logic [6:0] a);
    isAddr = (b[7:1] == a);
  endfunction : isAddr

  // General call and every other address fall through to no hit
  assign addrHit = isAddr(addrByte, mainSel ? ADDR_MAIN_SET : ADDR_MAIN_CLR)
                   | (testOpen & isAddr(addrByte, ADDR_TEST));
  assign hsCode  = (addrByte[7:3] == HS_CODE_TOP);

endmodule : rsp_addr_match

// ===== rsp_slave_port_sva.sv
// Concurrent checks on the slave port's top-level pins.
// Assumes a single clock domain; bound onto every rsp_slave_port.
`timescale 1ns/100ps
module rsp_slave_port_sva
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // Serial bus pins
  input  wire logic       sclPin,
  input  wire logic       sdaPin,
  input  wire logic       sclOut,
  input  wire logic       sclOe,
  input  wire logic       sdaOut,
  input  wire logic       sdaOe,
  // Supply monitors, register side and status
  input  wire logic       interfaceSupplyUndervoltageLevel,
  input  wire logic       systemSupplyUndervoltageLevel,
  input  wire logic [7:0] regPtr,
  input  wire logic       regWrEn,
  input  wire logic       hsFilter
);
  // ==========================================================
  // Helper logic
  // ==========================================================
  logic [7:0] ptrHoldReg;
  logic       supplyOff;

  assign supplyOff = interfaceSupplyUndervoltageLevel
                  && systemSupplyUndervoltageLevel;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      ptrHoldReg <= 8'h00;
    else if (regWrEn)
      ptrHoldReg <= regPtr;
  end

  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_no_clock_drive: assert property (
    !sclOe && !sclOut && !sdaOut)
    else $error("clock line or data level driven");
  a_supply_off_float: assert property (
    supplyOff [*4] |-> !sdaOe)
    else $error("data pulled low with both supplies off");
  a_data_stable_high: assert property (
    sclPin && $past(sclPin) |-> $stable(sdaOe))
    else $error("data drive moved while clock high");
  a_drive_starts_low: assert property (
    $rose(sdaOe) |-> !sclPin)
    else $error("data drive began with clock high");
  a_write_during_ack: assert property (
    regWrEn && !supplyOff |-> sdaOe)
    else $error("register write outside the acknowledge");
  a_ptr_step_write: assert property (
    regWrEn |-> ##[1:20] (regPtr == ptrHoldReg + 8'h01))
    else $error("pointer did not step after a data byte");
  a_stop_keeps_ptr: assert property (
    sclPin && $rose(sdaPin) |=> $stable(regPtr) [*8])
    else $error("pointer changed at a stop");
  a_stop_clears_filter: assert property (
    sclPin && $rose(sdaPin) |-> ##[1:12] !hsFilter)
    else $error("filters not slowed after a stop");
endmodule : rsp_slave_port_sva

bind rsp_slave_port rsp_slave_port_sva u_rsp_slave_port_sva (
  .clk(clk), .rst_b(rst_b), .sclPin(sclPin), .sdaPin(sdaPin),
  .sclOut(sclOut), .sclOe(sclOe), .sdaOut(sdaOut), .sdaOe(sdaOe),
  .interfaceSupplyUndervoltageLevel(interfaceSupplyUndervoltageLevel),
  .systemSupplyUndervoltageLevel(systemSupplyUndervoltageLevel),
  .regPtr(regPtr), .regWrEn(regWrEn), .hsFilter(hsFilter));

// ===== rsp_master_model.sv
// Behavioural bus master: open-drain wires with pull-ups, clock at rest
// high between frames. Assumes its tasks are called from one process.
`timescale 1ns/100ps
module rsp_master_model
(
  // Clock
  input  wire logic clk,
  // Device drive enables
  input  wire logic sclOe,
  input  wire logic sdaOe,
  // Wire levels
  output logic      sclPin,
  output logic      sdaPin
);
  // Bit time is kept long enough for the pin filter and sync delay
  localparam int TICK = 4;
  logic sclDrv = 1'b1;
  logic sdaDrv = 1'b1;

  // ==========================================================
  // Wires: released lines read high
  // ==========================================================
  assign sclPin = sclDrv && !sclOe;
  assign sdaPin = sdaDrv && !sdaOe;

  // ==========================================================
  // Bus steps
  // ==========================================================
  task automatic wt(input int n);
    repeat (n * TICK) @(negedge clk);
  endtask : wt

  // Data moves only with the clock low; sampled at the end of high
  task automatic bitX(input logic v, output logic s);
    wt(1);
    sdaDrv = v;
    wt(2);
    sclDrv = 1'b1;
    wt(2);
    s = sdaPin;
    sclDrv = 1'b0;
  endtask : bitX

  // Serves as start from idle and as repeated start
  task automatic startC();
    wt(1);
    sdaDrv = 1'b1;
    wt(2);
    sclDrv = 1'b1;
    wt(2);
    sdaDrv = 1'b0;
    wt(2);
    sclDrv = 1'b0;
  endtask : startC

  task automatic stopC();
    wt(1);
    sdaDrv = 1'b0;
    wt(2);
    sclDrv = 1'b1;
    wt(2);
    sdaDrv = 1'b1;
    wt(4);
  endtask : stopC

  task automatic sendByte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bitX(b[i], s);
    bitX(1'b1, s);
    ack = !s;
  endtask : sendByte

  task automatic recvByte(input logic mAck, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
      bitX(1'b1, b[i]);
    bitX(!mAck, s);
  endtask : recvByte
endmodule : rsp_master_model

// ===== tb_i2c_register_slave_port.sv
// Self-checking bench for the two-wire register slave port.
// Assumes the register file here answers regRdData in the same cycle.
`timescale 1ns/100ps
module tb_i2c_register_slave_port
  import rsp_pkg::*;
;
  localparam int LIMIT = 40000;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        addrSel = 1'b1;
  logic        testUnlock = 1'b0;
  logic        ifaceUv = 1'b0;
  logic        sysUv = 1'b0;
  logic        sclPin, sdaPin, sclOut, sclOe, sdaOut, sdaOe;
  logic [7:0]  regPtr, regWrData, regRdData;
  logic        regWrEn, regRdEn, hsFilter;
  logic [7:0]  regMem [256];
  logic [7:0]  expMem [256];
  logic [15:0] expQ [$];
  logic [6:0]  mainA, otherA;
  int          miscompares = 0;
  int          compares = 0;
  int          rdPulses = 0;
  int          cyc = 0;

  // ==========================================================
  // Clock, register file, instances
  // ==========================================================
  always #10 clk = ~clk;
  assign regRdData = regMem[regPtr];

  rsp_master_model u_rsp_master_model (.clk(clk), .sclOe(sclOe),
    .sdaOe(sdaOe), .sclPin(sclPin), .sdaPin(sdaPin));
  rsp_slave_port u_rsp_slave_port (.clk(clk), .rst_b(rst_b),
    .sclPin(sclPin), .sdaPin(sdaPin), .sclOut(sclOut), .sclOe(sclOe),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .addrSel(addrSel),
    .testUnlock(testUnlock), .interfaceSupplyUndervoltageLevel(ifaceUv),
    .systemSupplyUndervoltageLevel(sysUv), .regPtr(regPtr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regRdData(regRdData), .hsFilter(hsFilter));

  // ==========================================================
  // Checking and report
  // ==========================================================
  task automatic check(input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: expected %h got %h", $time, exp, got);
    end
  endtask : check

  task automatic final_report();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report

  // An empty queue yields unknowns, so a stray write always mismatches;
  // strobes are looked at mid-cycle, where they have settled
  always @(negedge clk)
  begin
    if (regRdEn === 1'b1)
      rdPulses++;
    if (regWrEn === 1'b1)
    begin
      check(expQ.size() > 0 ? expQ.pop_front() : 16'hXXXX,
            {regPtr, regWrData});
      regMem[regPtr] <= regWrData;
    end
  end

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      miscompares++;
      final_report();
    end
  end

  // ==========================================================
  // Sequences
  // ==========================================================
  task automatic doReset(input logic sel);
    rst_b = 1'b0;
    addrSel = sel;
    repeat (20) @(negedge clk);
    check(16'h0000, {6'h00, sdaOe, hsFilter, regPtr});
    rst_b = 1'b1;
    repeat (10) @(negedge clk);
    mainA = sel ? ADDR_MAIN_SET : ADDR_MAIN_CLR;
    otherA = sel ? ADDR_MAIN_CLR : ADDR_MAIN_SET;
  endtask : doReset

  task automatic probe(input logic [7:0] b, input logic exp);
    logic ack;
    u_rsp_master_model.startC();
    u_rsp_master_model.sendByte(b, ack);
    check(16'(exp), 16'(ack));
    u_rsp_master_model.stopC();
  endtask : probe

  task automatic head(input logic [7:0] ptr);
    logic ack;
    u_rsp_master_model.startC();
    u_rsp_master_model.sendByte({mainA, 1'b0}, ack);
    check(16'h0001, 16'(ack));
    u_rsp_master_model.sendByte(ptr, ack);
    check(16'h0001, 16'(ack));
  endtask : head

  task automatic wrSeq(input logic [7:0] ptr, input int n);
    logic ack;
    logic [7:0] d;
    head(ptr);
    for (int k = 0; k < n; k++)
    begin
      d = 8'($urandom);
      expQ.push_back({8'(ptr + k), d});
      expMem[8'(ptr + k)] = d;
      u_rsp_master_model.sendByte(d, ack);
      check(16'h0001, 16'(ack));
    end
    u_rsp_master_model.stopC();
    check({8'h00, 8'(ptr + n)}, {8'h00, regPtr});
  endtask : wrSeq

  task automatic rdSeq(input logic [7:0] ptr, input int n);
    logic ack;
    logic [7:0] d;
    int p0;
    head(ptr);
    p0 = rdPulses;
    u_rsp_master_model.startC();
    u_rsp_master_model.sendByte({mainA, 1'b1}, ack);
    check(16'h0001, 16'(ack));
    for (int k = 0; k < n; k++)
    begin
      u_rsp_master_model.recvByte(k < n - 1, d);
      check({8'h00, expMem[8'(ptr + k)]}, {8'h00, d});
    end
    u_rsp_master_model.stopC();
    check(16'(n), 16'(rdPulses - p0));
  endtask : rdSeq

  initial
  begin
    logic ack;
    void'($urandom(32'h5a93));
    for (int i = 0; i < 256; i++)
    begin
      regMem[i] = 8'(i * 7);
      expMem[i] = 8'(i * 7);
    end
    // Second pass is a mid-run reset with the other address option
    for (int s = 1; s >= 0; s--)
    begin
      doReset(s[0]);
      probe({mainA, 1'b0}, 1'b1);
      probe({otherA, 1'b0}, 1'b0);
      probe({ADDR_TEST, 1'b1}, 1'b0);
      testUnlock = 1'b1;
      probe({ADDR_TEST, 1'b0}, 1'b1);
      testUnlock = 1'b0;
      probe(8'h00, 1'b0);
      probe({3'h5, 4'($urandom), 1'b0}, 1'b0);
    end
    u_rsp_master_model.startC();
    u_rsp_master_model.sendByte({otherA, 1'b0}, ack);
    u_rsp_master_model.sendByte({mainA, 1'b0}, ack);
    check(16'h0000, 16'(ack));
    u_rsp_master_model.stopC();
    wrSeq(8'hFE, 3);
    rdSeq(8'hFE, 3);
    rdSeq(8'($urandom), 2);
    u_rsp_master_model.startC();
    u_rsp_master_model.sendByte({HS_CODE_TOP, 3'($urandom)}, ack);
    check(16'h0000, 16'(ack));
    check(16'h0001, 16'(hsFilter));
    u_rsp_master_model.startC();
    u_rsp_master_model.sendByte({mainA, 1'b0}, ack);
    check(16'h0101, {7'h00, ack, 7'h00, hsFilter});
    u_rsp_master_model.stopC();
    check(16'h0000, 16'(hsFilter));
    ifaceUv = 1'b1;
    probe({mainA, 1'b0}, 1'b1);
    sysUv = 1'b1;
    probe({mainA, 1'b0}, 1'b0);
    ifaceUv = 1'b0;
    sysUv = 1'b0;
    rdSeq(8'hFE, 1);
    check(16'h0000, 16'(expQ.size()));
    final_report();
  end
endmodule : tb_i2c_register_slave_port
